// *** mtc_pkg.sv ***
// package of the multimode timer counter: register map, fields, encodings
// assumes a 32-bit classic wishbone slave with word-aligned registers
package mtc_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] COUNT_OFS = 8'h04;
   localparam logic [7:0] PERIOD_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] LATCH_OFS = 8'h10;

   // control word field positions
   localparam int MODE_LSB = 0;
   localparam int LEN_LSB = 2;
   localparam int DIV_LSB = 4;
   localparam int CLEAR_BIT = 6;
   localparam int ROLL_EN_BIT = 7;
   localparam int MATCH_EN_BIT = 8;
   localparam int GIE_BIT = 9;

   // status field positions
   localparam int ROLL_FLAG_BIT = 0;
   localparam int MATCH_FLAG_BIT = 1;
   localparam int DOWN_BIT = 2;
   localparam int PEND_BIT = 3;

   // reset values
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'h0000;
   localparam logic [2:0] DIV_RST = 3'h0;

   // counter ceilings per length
   localparam logic [15:0] CEIL_16 = 16'hFFFF;
   localparam logic [15:0] CEIL_12 = 16'h0FFF;
   localparam logic [15:0] CEIL_10 = 16'h03FF;
   localparam logic [15:0] CEIL_8 = 16'h00FF;

   // count_mode_select encodings
   typedef enum logic [1:0] {
      MODE_STOP = 2'b00,
      MODE_UP = 2'b01,
      MODE_CONT = 2'b10,
      MODE_UPDN = 2'b11
   } mtc_mode_t;

   // counter length encodings
   typedef enum logic [1:0] {
      LEN_16 = 2'b00,
      LEN_12 = 2'b01,
      LEN_10 = 2'b10,
      LEN_8 = 2'b11
   } mtc_len_t;

   // whole state of the timer core
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      logic level;
      logic [2:0] div;
      mtc_mode_t mode;
      mtc_len_t len;
      logic [1:0] divSel;
      logic rollEn;
      logic matchEn;
      logic global_interrupt_enable;
      logic [15:0] cnt;
      logic down;
      logic [15:0] latch;
      logic [15:0] buffer;
      logic pendValid;
      logic pendHigh;
      logic rollFlag;
      logic matchFlag;
      logic ack;
      logic [31:0] dat;
      logic irq;
      logic matchPulse;
   } mtc_state_t;

endpackage : mtc_pkg

// *** mtc_timer_core.sv ***
// counting core of a multimode timer with a wishbone register slave
// assumes the timer clock arrives unsynchronised on timerClk
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// design notes
//
// state and clocking
// - whole block state is one packed struct, registered once per ref_clk
// - every output is a field of that struct, so all come from flops
// - counting runs on detected timer pin rises, never on ref_clk alone
// - timer pin is slow against ref_clk; each phase needs two cycles
// - a faster timer pin would lose edges in the synchroniser
//
// timer pin synchroniser
// - three stages; only the second and third are compared
// - level follows the third stage once both agree
// - a rise is the agreed level going high while the old level is low
// - level starts low after reset, matching an idle low pin
// - a pin held high through reset gives one rise after release
//
// input divider
// - divides detected rises by one, two, four or eight
// - the divider state is hidden from software
// - the clear bit and reset both zero it
// - changing the divide setting mid-run may shorten one period
//
// counter length
// - ceiling is all ones of the chosen length
// - a count write is masked by the ceiling, so top bits read zero
// - shrinking the length leaves the count as is until it wraps
//
// period buffer and latch
// - software writes the buffer; the compare uses the latch
// - a write marks a transfer pending and notes the timer phase
// - a period not below the old one loads at once
// - a smaller one written in the high phase loads at once
// - a smaller one written in the low phase waits for the next rise,
//   so that rise still steps against the old period
// - while descending in up/down the transfer waits for zero
// - a pending transfer shows in the status word
//
// up mode
// - a latch of zero holds the counter at zero
// - a count at or above the latch rolls to zero on the next step
// - a latch above the ceiling also rolls to zero on the next step
//
// continuous mode
// - the latch takes no period role here
// - match flag is raised on entering the latch value
//
// up/down mode
// - the direction flop is kept while stopped
// - while stopped only the clear bit or reset turns it back upward
// - direction stays down at zero until the next step turns it up
// - a latch above the ceiling makes it behave as continuous
//
// flags and request
// - flags are set whatever the enables say
// - a hardware set in the same cycle as a clear wins
// - the request is a registered and of flag, own and global enable
// - period match pulse lasts one ref_clk cycle per match step
//
// register bus
// - classic single cycle; ack comes one cycle after the strobe
// - a strobe held past its ack is acked again every second cycle
// - read data holds until the next request
// - unmapped addresses read as zero and ignore writes
// - lanes two and three are ignored

module mtc_timer_core (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic timerClk,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq,
   output logic periodMatch,
   output logic [15:0] counterValue,
   output logic countDown
);
   import mtc_pkg::*;

   mtc_state_t r;
   mtc_state_t next_r;

   logic rise;
   logic tick;
   logic [2:0] divMask;
   logic [15:0] ceiling;
   logic req;
   logic wr;
   logic blocked;
   logic setRoll;
   logic setMatch;
   logic [15:0] inc;
   logic [15:0] dec;
   logic overCeil;
   logic [31:0] rdData;

   // stepping, bus and flag logic in one pass
   always_comb begin
      next_r = r;
      setRoll = 1'b0;
      setMatch = 1'b0;
      // three-stage synchroniser; a change counts when stages 2 and 3 agree
      next_r.sync1 = timerClk;
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      if (r.sync2 == r.sync3) begin
         next_r.level = r.sync3;
      end
      rise = (r.sync2 == r.sync3) && r.sync3 && !r.level;
      // input divider by 1, 2, 4 or 8
      case (r.divSel)
         2'd0: divMask = 3'h0;
         2'd1: divMask = 3'h1;
         2'd2: divMask = 3'h3;
         default: divMask = 3'h7;
      endcase
      if (rise) begin
         next_r.div = r.div + 3'h1;
      end
      tick = rise && ((r.div & divMask) == divMask);
      // ceiling by length
      case (r.len)
         LEN_16: ceiling = CEIL_16;
         LEN_12: ceiling = CEIL_12;
         LEN_10: ceiling = CEIL_10;
         default: ceiling = CEIL_8;
      endcase
      inc = r.cnt + 16'h0001;
      dec = r.cnt - 16'h0001;
      overCeil = r.latch > ceiling;
      // counting step, only on divided timer edges
      if (tick) begin
         case (r.mode)
            MODE_UP: begin
               if (overCeil || r.cnt >= r.latch) begin
                  next_r.cnt = COUNT_RST;
                  setRoll = 1'b1;
               end else begin
                  next_r.cnt = inc;
                  setMatch = (inc == r.latch);
               end
            end
            MODE_CONT: begin
               if (r.cnt >= ceiling) begin
                  next_r.cnt = COUNT_RST;
                  setRoll = 1'b1;
               end else begin
                  next_r.cnt = inc;
               end
               setMatch = (next_r.cnt == r.latch);
            end
            MODE_UPDN: begin
               if (overCeil) begin
                  // behaves as continuous, never turns down
                  next_r.down = 1'b0;
                  if (r.cnt >= ceiling) begin
                     next_r.cnt = COUNT_RST;
                     setRoll = 1'b1;
                  end else begin
                     next_r.cnt = inc;
                  end
               end else if (!r.down) begin
                  if (r.cnt >= r.latch) begin
                     // turn at the period (or a shrunk one)
                     next_r.down = (r.cnt != 16'h0000);
                     next_r.cnt = (r.cnt != 16'h0000) ? dec : r.cnt;
                     setRoll = (r.cnt == 16'h0001);
                  end else begin
                     next_r.cnt = inc;
                     setMatch = (inc == r.latch);
                  end
               end else begin
                  if (r.cnt == 16'h0000) begin
                     next_r.down = 1'b0;
                     next_r.cnt = (r.latch != 16'h0000) ? inc : r.cnt;
                     setMatch = (inc == r.latch);
                  end else begin
                     next_r.cnt = dec;
                     setRoll = (r.cnt == 16'h0001);
                  end
               end
            end
            default: begin
               next_r.cnt = r.cnt;
            end
         endcase
      end
      // period transfer: high phase acts now, low phase after one edge
      // a period not below the old one extends the count at once
      blocked = (r.mode == MODE_UPDN) && r.down && (r.cnt != 16'h0000);
      if (r.pendValid && !blocked && (r.pendHigh || rise ||
         r.buffer >= r.latch)) begin
         next_r.latch = r.buffer;
         next_r.pendValid = 1'b0;
      end
      // wishbone classic: answer one cycle after the strobe
      req = wb_cyc_i && wb_stb_i && !r.ack;
      wr = req && wb_we_i;
      next_r.ack = req;
      case (wb_adr_i)
         CTRL_OFS: rdData = {22'h00_0000, r.global_interrupt_enable, r.matchEn, r.rollEn, 1'b0,
            r.divSel, r.len, r.mode};
         COUNT_OFS: rdData = {16'h0000, r.cnt};
         PERIOD_OFS: rdData = {16'h0000, r.buffer};
         STATUS_OFS: rdData = {28'h000_0000, r.pendValid, r.down,
            r.matchFlag, r.rollFlag};
         LATCH_OFS: rdData = {16'h0000, r.latch};
         default: rdData = 32'h0000_0000;
      endcase
      if (req) begin
         next_r.dat = wb_we_i ? 32'h0000_0000 : rdData;
      end
      // flags: hardware set wins over software clear
      next_r.rollFlag = r.rollFlag | setRoll;
      next_r.matchFlag = r.matchFlag | setMatch;
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            CTRL_OFS: begin
               next_r.mode = mtc_mode_t'(wb_dat_i[MODE_LSB +: 2]);
               next_r.len = mtc_len_t'(wb_dat_i[LEN_LSB +: 2]);
               next_r.divSel = wb_dat_i[DIV_LSB +: 2];
               next_r.rollEn = wb_dat_i[ROLL_EN_BIT];
               if (wb_dat_i[CLEAR_BIT]) begin
                  next_r.cnt = COUNT_RST;
                  next_r.div = DIV_RST;
                  next_r.down = 1'b0;
               end
            end
            COUNT_OFS: begin
               next_r.cnt = wb_dat_i[15:0] & ceiling;
            end
            PERIOD_OFS: begin
               next_r.buffer[7:0] = wb_dat_i[7:0];
               next_r.pendValid = 1'b1;
               next_r.pendHigh = r.level;
            end
            STATUS_OFS: begin
               if (wb_dat_i[ROLL_FLAG_BIT] && !setRoll) begin
                  next_r.rollFlag = 1'b0;
               end
               if (wb_dat_i[MATCH_FLAG_BIT] && !setMatch) begin
                  next_r.matchFlag = 1'b0;
               end
            end
            default: begin
               next_r.dat = r.dat;
            end
         endcase
      end
      if (wr && wb_sel_i[1]) begin
         case (wb_adr_i)
            CTRL_OFS: begin
               next_r.matchEn = wb_dat_i[MATCH_EN_BIT];
               next_r.global_interrupt_enable = wb_dat_i[GIE_BIT];
            end
            COUNT_OFS: begin
               next_r.cnt[15:8] = wb_dat_i[15:8] & ceiling[15:8];
            end
            PERIOD_OFS: begin
               next_r.buffer[15:8] = wb_dat_i[15:8];
               next_r.pendValid = 1'b1;
               next_r.pendHigh = r.level;
            end
            default: begin
               next_r.dat = r.dat;
            end
         endcase
      end
      // request needs flag, own enable and global enable
      next_r.irq = (next_r.rollFlag && next_r.rollEn && next_r.global_interrupt_enable) ||
         (next_r.matchFlag && next_r.matchEn && next_r.global_interrupt_enable);
      next_r.matchPulse = setMatch;
   end

   // one register for the whole state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from state flops
   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;
   assign irq = r.irq;
   assign periodMatch = r.matchPulse;
   assign counterValue = r.cnt;
   assign countDown = r.down;

endmodule : mtc_timer_core

`default_nettype wire

// *** mtc_timer_core_asserts.sv ***
// port checker for the timer core: bus handshake and counting steps
// assumes one ref_clk domain with synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module mtc_core_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic irq,
   input wire logic periodMatch,
   input wire logic [15:0] counterValue,
   input wire logic countDown
);
   logic [2:0] wrHist;
   logic req;
   logic wr;
   // a recent bus write may load or clear the counter
   assign req = wb_cyc_i && wb_stb_i;
   assign wr = (req && wb_we_i) || (|wrHist);
   always_ff @(posedge ref_clk) begin
      wrHist <= {wrHist[1:0], req && wb_we_i};
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
      else $error("ack without request");
   match_pulse_a: assert property (periodMatch |=> !periodMatch)
      else $error("period match pulse too long");
   reset_state_a: assert property ($fell(rst) |->
      counterValue == 16'h0000 && !countDown && !irq)
      else $error("state after reset wrong");
   up_step_a: assert property (!countDown && !$past(countDown)
      && $changed(counterValue) && !wr |-> counterValue == 16'h0000
      || counterValue == $past(counterValue) + 16'h0001)
      else $error("upward step not plus one or zero");
   down_step_a: assert property (countDown && $past(countDown)
      && $changed(counterValue) && !wr && $past(counterValue) != 0
      |-> counterValue == $past(counterValue) - 16'h0001)
      else $error("downward step not minus one");
   step_gap_a: assert property ($changed(counterValue) && !wr
      |=> $stable(counterValue) [*2])
      else $error("counter stepped without a timer edge");
   // main scenarios reached
   cover property ($rose(countDown));
   cover property (periodMatch);
   cover property ($rose(irq));
endmodule : mtc_core_chk
bind mtc_timer_core mtc_core_chk chk_u (.ref_clk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_ack_o, .irq, .periodMatch, .counterValue,
   .countDown);
`default_nettype wire

// *** test_mtc_timer_core.sv ***
// self-checking bench for the timer core
// drives the wishbone port and the timer clock pin itself
`timescale 1ns/1ps
`default_nettype none
module test_mtc_timer_core;
   import mtc_pkg::*;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   logic ref_clk = 0, rst = 1, timerClk = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h3;
   logic [31:0] wdat = ZERO;
   logic [31:0] rdat, got;
   logic ack, irq, pm, down;
   logic [15:0] cnt;
   int n_mismatch = 0, comparisons = 0;
   int n_pm = 0;
   mtc_timer_core dut_u (.ref_clk, .rst, .timerClk, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq,
      .periodMatch(pm), .counterValue(cnt), .countDown(down));
   // 25 MHz system clock
   initial forever #20 ref_clk = ~ref_clk;
   // count period match pulses where they have settled
   always @(negedge ref_clk) if (pm === 1'b1) n_pm++;
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] exp,
         input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one classic cycle, held until ack, then one idle cycle
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int i;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      i = 0;
      do begin
         @(negedge ref_clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      @(posedge ref_clk);
      got = rdat;
      if (i >= 20) begin
         n_mismatch++;
         end_of_test();
      end
      cyc <= 0;
      stb <= 0;
      we <= 0;
      @(posedge ref_clk);
   endtask : bus
   task automatic rdchk(input string nm, input logic [7:0] a,
         input logic [31:0] exp);
      bus(0, a, ZERO);
      chk(nm, exp, got);
   endtask : rdchk
   // n timer clock periods, four system cycles per phase
   task automatic step(input int n);
      repeat (n) begin
         timerClk <= 1;
         repeat (4) @(posedge ref_clk);
         timerClk <= 0;
         repeat (4) @(posedge ref_clk);
      end
   endtask : step
   task automatic stepchk(input logic [15:0] exp);
      step(1);
      chk("count", 32'(exp), 32'(cnt));
   endtask : stepchk
   task automatic t_reset;
      rdchk("control", CTRL_OFS, ZERO);
      rdchk("count", COUNT_OFS, ZERO);
      rdchk("unmapped", 8'h14, ZERO);
      chk("down", ZERO, 32'(down));
   endtask : t_reset
   task automatic t_up;
      bus(1, PERIOD_OFS, 32'h0000_0003);
      bus(1, CTRL_OFS, 32'h0000_0281);
      stepchk(16'h0001);
      stepchk(16'h0002);
      stepchk(16'h0003);
      chk("match pulse", 32'h0000_0001, 32'(n_pm));
      rdchk("status", STATUS_OFS, 32'h0000_0002);
      chk("irq", ZERO, 32'(irq));
      stepchk(16'h0000);
      rdchk("status", STATUS_OFS, 32'h0000_0003);
      chk("irq", 32'h0000_0001, 32'(irq));
      bus(1, STATUS_OFS, 32'h0000_0003);
      @(posedge ref_clk);
      chk("irq", ZERO, 32'(irq));
   endtask : t_up
   task automatic t_stop;
      step(2);
      bus(1, CTRL_OFS, 32'h0000_0280);
      step(2);
      chk("count", 32'h0000_0002, 32'(cnt));
      bus(1, CTRL_OFS, 32'h0000_0281);
      stepchk(16'h0003);
   endtask : t_stop
   task automatic t_cont;
      bus(1, CTRL_OFS, 32'h0000_028C);
      bus(1, COUNT_OFS, 32'h0000_01FE);
      rdchk("count", COUNT_OFS, 32'h0000_00FE);
      bus(1, STATUS_OFS, 32'h0000_0003);
      bus(1, CTRL_OFS, 32'h0000_028E);
      stepchk(16'h00FF);
      stepchk(16'h0000);
      rdchk("status", STATUS_OFS, 32'h0000_0001);
   endtask : t_cont
   task automatic t_updn;
      bus(1, CTRL_OFS, 32'h0000_0040);
      bus(1, STATUS_OFS, 32'h0000_0003);
      bus(1, PERIOD_OFS, 32'h0000_0002);
      bus(1, CTRL_OFS, 32'h0000_0003);
      stepchk(16'h0001);
      stepchk(16'h0002);
      stepchk(16'h0001);
      bus(1, CTRL_OFS, ZERO);
      rdchk("status", STATUS_OFS, 32'h0000_0006);
      bus(1, CTRL_OFS, 32'h0000_0003);
      stepchk(16'h0000);
      rdchk("status", STATUS_OFS, 32'h0000_0007);
      step(3);
      bus(1, CTRL_OFS, 32'h0000_0043);
      chk("down", ZERO, 32'(down));
      chk("count", ZERO, 32'(cnt));
      stepchk(16'h0001);
   endtask : t_updn
   task automatic t_period;
      bus(1, CTRL_OFS, 32'h0000_0041);
      bus(1, PERIOD_OFS, 32'h0000_0003);
      step(2);
      bus(1, PERIOD_OFS, 32'h0000_000A);
      step(3);
      chk("count", 32'h0000_0005, 32'(cnt));
      bus(1, PERIOD_OFS, 32'h0000_0003);
      stepchk(16'h0006);
      stepchk(16'h0000);
      bus(1, PERIOD_OFS, 32'h0000_000A);
      step(5);
      timerClk <= 1;
      repeat (6) @(posedge ref_clk);
      bus(1, PERIOD_OFS, 32'h0000_0003);
      timerClk <= 0;
      repeat (4) @(posedge ref_clk);
      stepchk(16'h0000);
   endtask : t_period
   // reset, then each scenario in turn
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 0;
      @(posedge ref_clk);
      t_reset;
      t_up;
      t_stop;
      t_cont;
      t_updn;
      t_period;
      end_of_test;
   end
endmodule : test_mtc_timer_core
`default_nettype wire
